// *** hw/irp_dev_end.sv ***
// Device end: register access slave behind the two-wire port
`timescale 1ns/1ps
`default_nettype none
module irp_dev_end (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   // Link
   irp_link_if.dev link,
   // Configuration
   input wire logic i_auto_inc_mode,
   // Register file side
   output logic [6:0] o_reg_addr,
   output logic o_reg_wr,
   output logic [7:0] o_reg_wdata,
   output logic o_reg_rd,
   input wire logic [7:0] i_reg_rdata
);
   // ********************************************
   // State
   // ********************************************
   typedef struct packed {
      irp_pkg::irp_dev_st_t st;
      irp_pkg::irp_expect_t exp;
      logic rw;
      logic adv;
      logic [3:0] bitn;
      logic [7:0] sh;
      logic [6:0] ptr;
      logic scl_p;
      logic sda_p;
      logic sda_oe;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } irp_dev_state_t;
   irp_dev_state_t st_q;
   irp_dev_state_t st_d;

   logic scl_f;
   logic sda_f;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;

   // Pointer step shared by write and read auto-increment
   function automatic logic [6:0] ptr_next(input logic [6:0] p);
      return (p == irp_pkg::PTR_LAST) ? irp_pkg::PTR_FIRST : p + 7'h01;
   endfunction

   // ********************************************
   // Line conditioning
   // ********************************************
   // Both lines see the same delay so START and STOP keep their order
   irp_line_filter u_scl_filt (
      .i_ref_clk(i_ref_clk),
      .i_reset_n(i_reset_n),
      .i_line(link.scl),
      .o_level(scl_f)
   );

   irp_line_filter u_sda_filt (
      .i_ref_clk(i_ref_clk),
      .i_reset_n(i_reset_n),
      .i_line(link.sda),
      .o_level(sda_f)
   );

   // ********************************************
   // Bus events
   // ********************************************
   // Clock is only ever sampled, never driven from this end
   assign scl_rise = scl_f & !st_q.scl_p;
   assign scl_fall = !scl_f & st_q.scl_p;
   // Data edges count as conditions only while clock stays high
   assign start_seen = scl_f & st_q.scl_p & st_q.sda_p & !sda_f;
   assign stop_seen = scl_f & st_q.scl_p & !st_q.sda_p & sda_f;

   // ********************************************
   // Protocol engine
   // ********************************************
   // All register activity follows serial clock edges as sampled on i_ref_clk, so the
   // port only works while i_ref_clk is running
   always_comb begin
      st_d = st_q;
      st_d.wr = 1'h0;
      st_d.rd = 1'h0;
      st_d.scl_p = scl_f;
      st_d.sda_p = sda_f;
      if (start_seen) begin
         // A repeated START cuts any sequence short and rearms address
         st_d.st = irp_pkg::DS_RX;
         st_d.exp = irp_pkg::EXP_DAB;
         st_d.bitn = 4'h0;
         st_d.adv = 1'h0;
         st_d.sda_oe = 1'h0;
      end else if (stop_seen) begin
         st_d.st = irp_pkg::DS_IDLE;
         st_d.adv = 1'h0;
         st_d.sda_oe = 1'h0;
      end else begin
         case (st_q.st)
            irp_pkg::DS_RX: begin
               if (scl_rise) begin
                  // Data is taken on the rising clock, stable while high
                  st_d.sh = {st_q.sh[6:0], sda_f};
                  st_d.bitn = st_q.bitn + 4'h1;
               end else if (scl_fall && st_q.bitn == irp_pkg::ACK_BIT) begin
                  st_d.bitn = 4'h0;
                  st_d.st = irp_pkg::DS_ACK;
                  st_d.sda_oe = 1'h1;
                  case (st_q.exp)
                     irp_pkg::EXP_DAB: begin
                        if (st_q.sh[7:1] == irp_pkg::DEV_ADDR) begin
                           st_d.rw = st_q.sh[0];
                           st_d.exp = irp_pkg::EXP_RAB;
                        end else begin
                           // Not ours: stay off the line until the next condition
                           st_d.st = irp_pkg::DS_SKIP;
                           st_d.sda_oe = 1'h0;
                        end
                     end
                     irp_pkg::EXP_RAB: begin
                        // Top bit of the register address byte is ignored
                        st_d.ptr = st_q.sh[6:0];
                        st_d.exp = irp_pkg::EXP_DATA;
                     end
                     default: begin
                        st_d.wr = 1'h1;
                        st_d.wdata = st_q.sh;
                        st_d.adv = 1'h1;
                     end
                  endcase
               end
            end
            irp_pkg::DS_ACK: begin
               // Ack held low through the whole high phase, dropped on the fall
               if (scl_fall) begin
                  st_d.sda_oe = 1'h0;
                  st_d.adv = 1'h0;
                  if (st_q.rw == irp_pkg::DIR_READ) begin
                     st_d.st = irp_pkg::DS_TX;
                     st_d.rd = 1'h1;
                     st_d.sh = i_reg_rdata;
                     st_d.sda_oe = !i_reg_rdata[7];
                  end else begin
                     st_d.st = irp_pkg::DS_RX;
                     if (st_q.adv) begin
                        // Pointer moves after the ack so the write strobe
                        // still saw the address it was meant for
                        if (!i_auto_inc_mode) begin
                           st_d.exp = irp_pkg::EXP_RAB;
                        end else if (st_q.ptr == irp_pkg::PTR_LAST) begin
                           st_d.exp = irp_pkg::EXP_RAB;
                        end else begin
                           st_d.ptr = ptr_next(st_q.ptr);
                        end
                     end
                  end
               end
            end
            irp_pkg::DS_TX: begin
               if (scl_rise) begin
                  st_d.bitn = st_q.bitn + 4'h1;
               end else if (scl_fall) begin
                  if (st_q.bitn == irp_pkg::ACK_BIT) begin
                     // Hand the line to the master for its ack slot
                     st_d.sda_oe = 1'h0;
                     st_d.st = irp_pkg::DS_MACK;
                  end else begin
                     // Next bit goes out just after the fall, never while high
                     st_d.sh = {st_q.sh[6:0], 1'h0};
                     st_d.sda_oe = !st_q.sh[6];
                  end
               end
            end
            irp_pkg::DS_MACK: begin
               if (scl_rise) begin
                  st_d.bitn = 4'h0;
                  // Master ack (low) asks for another byte
                  st_d.adv = !sda_f;
                  if (i_auto_inc_mode) begin
                     st_d.ptr = ptr_next(st_q.ptr);
                  end
               end else if (scl_fall) begin
                  if (st_q.adv) begin
                     st_d.st = irp_pkg::DS_TX;
                     st_d.rd = 1'h1;
                     st_d.sh = i_reg_rdata;
                     st_d.sda_oe = !i_reg_rdata[7];
                  end else begin
                     // Withheld ack: line stays released for STOP or restart
                     st_d.st = irp_pkg::DS_SKIP;
                     st_d.sda_oe = 1'h0;
                  end
                  st_d.adv = 1'h0;
               end
            end
            default: begin
               // Idle and skip just wait for the next START
               st_d.sda_oe = 1'h0;
            end
         endcase
      end
   end

   // ********************************************
   // State register
   // ********************************************
   // Line history starts high to match a released bus
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_q <= '0;
         st_q.st <= irp_pkg::DS_IDLE;
         st_q.exp <= irp_pkg::EXP_DAB;
         st_q.scl_p <= 1'h1;
         st_q.sda_p <= 1'h1;
      end else begin
         st_q <= st_d;
      end
   end

   // ********************************************
   // Outputs
   // ********************************************
   // Open drain: the pin only ever pulls low or lets go
   assign link.d_sda_o = 1'h0;
   assign link.d_sda_oe = st_q.sda_oe;
   assign o_reg_addr = st_q.ptr;
   assign o_reg_wr = st_q.wr;
   assign o_reg_wdata = st_q.wdata;
   assign o_reg_rd = st_q.rd;
endmodule
`default_nettype wire

// *** hw/irp_pkg.sv ***
// Shared constants and types for the two-wire register port, both ends
// Overview of operation
// - Data falling while clock high starts transfer
// - Data rising while clock high stops transfer
// - Data changes only while clock is low
// - Device never drives clock; master makes pulses
// - Idle bus: both lines released high (here the host end drives scl high)
// - Device data pin open-drain, wired-AND
// - Works up to 400 kbit/s
// - Device answers address 1110101; bit0 direction
// - Direction zero writes, one reads
// - After write address, next byte is register address
// - Register address loads the pointer for access
// - Device acknowledges every written byte, stable low
// - Master releases data during written-byte acknowledge
// - Alternating: data then new register address
// - Auto-increment: pointer steps after written byte
// - Past pointer 4F, next byte is new address
// - STOP or repeated START ends auto-increment
// - Master withholds last read ack; device releases
// - Read: addr write, reg addr, restart, addr read
// - Alternating read: restart and address before each
// - Auto-increment read steps pointer, wraps 4F to 00
// - Writes timed only by serial clock edges (here the write strobe is an i_ref_clk pulse after the filtered edge)
`default_nettype none
package irp_pkg;
   // ********************************************
   // Timing
   // ********************************************
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned LINK_BPS = 400_000;
   // Quarter bit period, rounded up so the bit rate never exceeds the limit
   localparam int unsigned QTR_CYC = (CLK_HZ + 4 * LINK_BPS - 1) / (4 * LINK_BPS);
   localparam int unsigned FILT_LEN = 3;
   // ********************************************
   // Protocol values
   // ********************************************
   localparam logic [6:0] DEV_ADDR = 7'h75;
   localparam logic [6:0] PTR_LAST = 7'h4F;
   localparam logic [6:0] PTR_FIRST = 7'h00;
   localparam logic DIR_WRITE = 1'h0;
   localparam logic DIR_READ = 1'h1;
   localparam logic [3:0] ACK_BIT = 4'h8;
   // ********************************************
   // Types
   // ********************************************
   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      OP_START = 3'h1,
      OP_TX = 3'h2,
      OP_RX = 3'h3,
      OP_STOP = 3'h4
   } irp_op_t;
   typedef struct packed {
      irp_op_t op;
      logic [7:0] data;
   } irp_step_t;
   typedef enum logic [1:0] {
      EXP_DAB = 2'h0,
      EXP_RAB = 2'h1,
      EXP_DATA = 2'h2
   } irp_expect_t;
   typedef enum logic [2:0] {
      DS_IDLE = 3'h0,
      DS_RX = 3'h1,
      DS_ACK = 3'h2,
      DS_TX = 3'h3,
      DS_MACK = 3'h4,
      DS_SKIP = 3'h5
   } irp_dev_st_t;
endpackage
`default_nettype wire

// *** hw/irp_link_if.sv ***
// Two-wire link joining the host end and the device end
`timescale 1ns/1ps
`default_nettype none
interface irp_link_if;
   logic scl_o;
   logic scl_oe;
   logic m_sda_o;
   logic m_sda_oe;
   logic d_sda_o;
   logic d_sda_oe;
   logic scl;
   logic sda;
   // Released lines rest high through the pull-up; data is wired-AND
   assign scl = scl_oe ? scl_o : 1'h1;
   assign sda = (m_sda_oe ? m_sda_o : 1'h1) & (d_sda_oe ? d_sda_o : 1'h1);
   modport host (output scl_o, output scl_oe, output m_sda_o, output m_sda_oe, input sda);
   modport dev (output d_sda_o, output d_sda_oe, input scl, input sda);
endinterface
`default_nettype wire

// *** hw/irp_line_filter.sv ***
// Two-stage synchroniser followed by a stable-count glitch filter
`timescale 1ns/1ps
`default_nettype none
module irp_line_filter #(
   parameter int unsigned LEN = irp_pkg::FILT_LEN
) (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   // Raw line and cleaned level
   input wire logic i_line,
   output logic o_level
);
   typedef struct packed {
      logic meta;
      logic sync;
      logic [3:0] cnt;
      logic level;
   } irp_filt_t;
   irp_filt_t st_q;
   irp_filt_t st_d;

   // A new level must hold LEN samples; shorter spikes are dropped
   always_comb begin
      st_d = st_q;
      st_d.meta = i_line;
      st_d.sync = st_q.meta;
      if (st_q.sync == st_q.level) begin
         st_d.cnt = 4'h0;
      end else if (st_q.cnt == 4'(LEN - 1)) begin
         st_d.level = st_q.sync;
         st_d.cnt = 4'h0;
      end else begin
         st_d.cnt = st_q.cnt + 4'h1;
      end
   end

   // Lines idle high, so the filter starts high
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_q <= '{meta: 1'h1, sync: 1'h1, cnt: 4'h0, level: 1'h1};
      end else begin
         st_q <= st_d;
      end
   end

   assign o_level = st_q.level;
endmodule
`default_nettype wire

// *** hw/irp_host_end.sv ***
// Bus master end: issues single-register writes and reads
`timescale 1ns/1ps
`default_nettype none
module irp_host_end (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   // Link
   irp_link_if.host link,
   // Command port
   input wire logic i_cmd_valid,
   input wire logic i_cmd_write,
   input wire logic [6:0] i_cmd_reg,
   input wire logic [7:0] i_cmd_wdata,
   output logic o_cmd_ready,
   // Result port
   output logic o_done,
   output logic [7:0] o_rdata,
   output logic o_nack_err
);
   typedef struct packed {
      logic run;
      logic wr;
      logic [6:0] rg;
      logic [7:0] wd;
      logic [2:0] idx;
      irp_pkg::irp_op_t op;
      logic [1:0] ph;
      logic [3:0] bitn;
      logic [7:0] sh;
      logic [4:0] div;
      logic scl_o;
      logic scl_oe;
      logic sda_oe;
      logic ready;
      logic done;
      logic nack;
      logic [7:0] rdata;
   } irp_host_st_t;
   irp_host_st_t st_q;
   irp_host_st_t st_d;
   logic sda_f;
   logic tick;
   irp_pkg::irp_step_t nxt;

   // Transaction script; every register address is sent before its data
   function automatic irp_pkg::irp_step_t step_op(input logic wr, input logic [2:0] idx,
                                                   input logic [6:0] rg, input logic [7:0] wd);
      irp_pkg::irp_step_t s;
      s = '{op: irp_pkg::OP_NONE, data: 8'h00};
      case (idx)
         3'h0: s.op = irp_pkg::OP_START;
         3'h1: s = '{irp_pkg::OP_TX, {irp_pkg::DEV_ADDR, irp_pkg::DIR_WRITE}};
         3'h2: s = '{irp_pkg::OP_TX, {1'h0, rg}};
         3'h3: begin
            if (wr) begin
               s = '{irp_pkg::OP_TX, wd};
            end else begin
               s.op = irp_pkg::OP_START;
            end
         end
         3'h4: begin
            if (wr) begin
               s.op = irp_pkg::OP_STOP;
            end else begin
               s = '{irp_pkg::OP_TX, {irp_pkg::DEV_ADDR, irp_pkg::DIR_READ}};
            end
         end
         3'h5: s.op = wr ? irp_pkg::OP_NONE : irp_pkg::OP_RX;
         3'h6: s.op = wr ? irp_pkg::OP_NONE : irp_pkg::OP_STOP;
         default: s.op = irp_pkg::OP_NONE;
      endcase
      return s;
   endfunction

   // Read-back of the data line comes from the pin, so it is synchronised
   irp_line_filter u_sda_filt (
      .i_ref_clk(i_ref_clk),
      .i_reset_n(i_reset_n),
      .i_line(link.sda),
      .o_level(sda_f)
   );

   // Quarter-bit enable from the divider paces the whole sequencer
   assign tick = (st_q.div == 5'(irp_pkg::QTR_CYC - 1));
   assign nxt = step_op(st_q.wr, st_q.idx + 3'h1, st_q.rg, st_q.wd);

   // Sequencer: four quarters per bit, scl low in quarters 0 and 1
   always_comb begin
      st_d = st_q;
      st_d.done = 1'h0;
      st_d.scl_oe = 1'h1;
      if (!st_q.run) begin
         st_d.div = 5'h0;
         st_d.ready = 1'h1;
         if (i_cmd_valid && st_q.ready) begin
            st_d.run = 1'h1;
            st_d.ready = 1'h0;
            st_d.wr = i_cmd_write;
            st_d.rg = i_cmd_reg;
            st_d.wd = i_cmd_wdata;
            st_d.idx = 3'h0;
            st_d.op = irp_pkg::OP_START;
            st_d.ph = 2'h0;
            st_d.bitn = 4'h0;
            st_d.nack = 1'h0;
         end
      end else if (!tick) begin
         st_d.div = st_q.div + 5'h1;
      end else begin
         st_d.div = 5'h0;
         st_d.ph = st_q.ph + 2'h1;
         case (st_q.op)
            irp_pkg::OP_START: begin
               if (st_q.ph == 2'h0) st_d.sda_oe = 1'h0;
               if (st_q.ph == 2'h1) st_d.scl_o = 1'h1;
               if (st_q.ph == 2'h2) st_d.sda_oe = 1'h1;
               if (st_q.ph == 2'h3) st_d.scl_o = 1'h0;
            end
            irp_pkg::OP_STOP: begin
               if (st_q.ph == 2'h0) st_d.sda_oe = 1'h1;
               if (st_q.ph == 2'h1) st_d.scl_o = 1'h1;
               if (st_q.ph == 2'h2) st_d.sda_oe = 1'h0;
            end
            default: begin
               if (st_q.ph == 2'h0) begin
                  // Released in the ack slot; on a read this is the withheld ack
                  st_d.sda_oe = (st_q.op == irp_pkg::OP_TX && st_q.bitn != irp_pkg::ACK_BIT)
                                ? !st_q.sh[7] : 1'h0;
               end
               if (st_q.ph == 2'h1) st_d.scl_o = 1'h1;
               if (st_q.ph == 2'h2) begin
                  if (st_q.op == irp_pkg::OP_TX && st_q.bitn == irp_pkg::ACK_BIT) begin
                     st_d.nack = st_q.nack | sda_f;
                  end else if (st_q.op == irp_pkg::OP_RX && st_q.bitn != irp_pkg::ACK_BIT) begin
                     st_d.sh = {st_q.sh[6:0], sda_f};
                  end else if (st_q.op == irp_pkg::OP_RX) begin
                     st_d.rdata = st_q.sh;
                  end
               end
               if (st_q.ph == 2'h3) begin
                  st_d.scl_o = 1'h0;
                  st_d.bitn = st_q.bitn + 4'h1;
                  if (st_q.op == irp_pkg::OP_TX) st_d.sh = {st_q.sh[6:0], 1'h0};
               end
            end
         endcase
         // Step to the next part of the script after the last quarter
         if (st_q.ph == 2'h3 && (st_q.op != irp_pkg::OP_TX && st_q.op != irp_pkg::OP_RX
                                 || st_q.bitn == irp_pkg::ACK_BIT)) begin
            st_d.idx = st_q.idx + 3'h1;
            st_d.op = nxt.op;
            st_d.sh = nxt.data;
            st_d.bitn = 4'h0;
            if (nxt.op == irp_pkg::OP_NONE) begin
               st_d.run = 1'h0;
               st_d.done = 1'h1;
            end
         end
      end
   end

   // State register
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_q <= '0;
         st_q.scl_o <= 1'h1;
         st_q.op <= irp_pkg::OP_NONE;
      end else begin
         st_q <= st_d;
      end
   end

   assign link.scl_o = st_q.scl_o;
   assign link.scl_oe = st_q.scl_oe;
   assign link.m_sda_o = 1'h0;
   assign link.m_sda_oe = st_q.sda_oe;
   assign o_cmd_ready = st_q.ready;
   assign o_done = st_q.done;
   assign o_rdata = st_q.rdata;
   assign o_nack_err = st_q.nack;
endmodule
`default_nettype wire

// *** tb/irp_link_assertions.sv ***
// Concurrent checks on the two-wire link between the host and device ends
`timescale 1ns/1ps
`default_nettype none
module irp_link_assertions (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   // Link signals
   input wire logic m_sda_o,
   input wire logic m_sda_oe,
   input wire logic d_sda_o,
   input wire logic d_sda_oe,
   input wire logic scl,
   input wire logic sda
);
   // ***************************************************
   // Link rules
   // ***************************************************
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);
   // Start: data held low, then the clock falls to begin the first bit
   sequence s_start_hold;
      m_sda_oe [*8];
   endsequence
   property p_start;
      $rose(m_sda_oe) && scl |-> s_start_hold ##[1:30] !scl;
   endproperty
   a_start: assert property (p_start) else $error("start shape wrong");
   // Host may touch data under a high clock only mid-phase (start or stop)
   property p_host_change;
      $changed(m_sda_oe) && scl |-> $past(scl, 3);
   endproperty
   a_host_change: assert property (p_host_change) else $error("host data moved");
   property p_dev_stable;
      scl && $past(scl) |-> $stable(d_sda_oe);
   endproperty
   a_dev_stable: assert property (p_dev_stable) else $error("device data moved");
   // Minimum high and low phases of 8 cycles each cap the rate at 1.25 Mbit/s, above the limit
   property p_scl_high;
      $rose(scl) |-> scl [*8];
   endproperty
   a_scl_high: assert property (p_scl_high) else $error("clock high too short");
   property p_scl_low;
      $fell(scl) |-> (!scl) [*8];
   endproperty
   a_scl_low: assert property (p_scl_low) else $error("clock low too short");
   property p_ack_hold;
      $rose(scl) && d_sda_oe |-> d_sda_oe throughout (##[1:40] $fell(scl));
   endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("device low not held");
   property p_open_drain;
      d_sda_o == 1'b0 && m_sda_o == 1'b0;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("data driven high");
   property p_no_contend;
      scl && d_sda_oe |-> !m_sda_oe;
   endproperty
   a_no_contend: assert property (p_no_contend) else $error("both pull data");
endmodule
`default_nettype wire

// *** tb/i2c_register_port_slave_tb_top.sv ***
// Self-checking bench: host end and device end joined over the link
`timescale 1ns/1ps
`default_nettype none
module i2c_register_port_slave_tb_top;
   // ***************************************************
   // Signals and model
   // ***************************************************
   logic i_ref_clk = 1'b0;
   logic i_reset_n = 1'b0;
   logic cmd_valid = 1'b0;
   logic cmd_write = 1'b0;
   logic [6:0] cmd_reg = 7'h00;
   logic [7:0] cmd_wdata = 8'h00;
   logic auto_mode = 1'b0;
   logic cmd_ready, done, nack_err, reg_wr, reg_rd;
   logic [7:0] rdata, reg_wdata, reg_rdata, wd;
   logic [6:0] reg_addr, wa;
   logic [7:0] regs [128];
   logic [31:0] seed = 32'h1e3e_45c1;
   int model [128];
   int wr_cnt = 0;
   int rd_cnt = 0;
   int failures = 0;
   int n_checks = 0;
   // Free-running reference clock
   always #25 i_ref_clk = ~i_ref_clk;
   irp_link_if link_inst();
   irp_host_end irp_host_end_inst(.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
      .link(link_inst), .i_cmd_valid(cmd_valid), .i_cmd_write(cmd_write),
      .i_cmd_reg(cmd_reg), .i_cmd_wdata(cmd_wdata), .o_cmd_ready(cmd_ready),
      .o_done(done), .o_rdata(rdata), .o_nack_err(nack_err));
   irp_dev_end irp_dev_end_inst(.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
      .link(link_inst), .i_auto_inc_mode(auto_mode), .o_reg_addr(reg_addr),
      .o_reg_wr(reg_wr), .o_reg_wdata(reg_wdata), .o_reg_rd(reg_rd),
      .i_reg_rdata(reg_rdata));
   irp_link_assertions irp_link_assertions_inst(.i_ref_clk(i_ref_clk),
      .i_reset_n(i_reset_n), .m_sda_o(link_inst.m_sda_o), .m_sda_oe(link_inst.m_sda_oe),
      .d_sda_o(link_inst.d_sda_o), .d_sda_oe(link_inst.d_sda_oe),
      .scl(link_inst.scl), .sda(link_inst.sda));
   // User register file; also records each write strobe for comparison
   always @(posedge i_ref_clk) begin
      if (reg_wr === 1'b1) begin
         wr_cnt <= wr_cnt + 1;
         wa <= reg_addr;
         wd <= reg_wdata;
         regs[reg_addr] <= reg_wdata;
      end
      if (reg_rd === 1'b1) begin
         rd_cnt <= rd_cnt + 1;
      end
   end
   assign reg_rdata = regs[reg_addr];
   // ***************************************************
   // Tasks
   // ***************************************************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // One command: wait for ready, present for one accept edge, wait for done
   task automatic do_cmd(input logic w, input logic [6:0] rg, input logic [7:0] wdv);
      int t;
      t = 0;
      while (cmd_ready !== 1'b1 && t < 100) begin
         @(negedge i_ref_clk);
         t++;
      end
      if (t >= 100) begin
         failures++;
         tally_and_finish();
      end
      @(posedge i_ref_clk);
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_reg <= rg;
      cmd_wdata <= wdv;
      @(posedge i_ref_clk);
      cmd_valid <= 1'b0;
      while (done !== 1'b1 && t < 5000) begin
         @(negedge i_ref_clk);
         t++;
      end
      if (t >= 5000) begin
         failures++;
         tally_and_finish();
      end
   endtask
   // ***************************************************
   // Main sequence: both modes, six registers each, write then read back each one
   // ***************************************************
   initial begin
      logic [6:0] rg;
      logic [7:0] dv;
      logic [6:0] nx;
      int c0;
      repeat (6) @(posedge i_ref_clk);
      i_reset_n <= 1'b1;
      repeat (2) @(posedge i_ref_clk);
      for (int m = 0; m < 2; m++) begin
         @(posedge i_ref_clk);
         auto_mode <= m[0];
         for (int n = 0; n < 6; n++) begin
            seed = lfsr(seed);
            rg = (n == 0) ? 7'h4f : 7'(seed[6:0] % 7'h4f);
            dv = seed[15:8];
            // Pointer step by the rules: one up, wrapping after the last register
            nx = (rg == 7'h4f) ? 7'h00 : rg + 7'h01;
            c0 = wr_cnt;
            do_cmd(1'b1, rg, dv);
            chk(32'(wr_cnt), 32'(c0 + 1));
            chk(32'(wa), 32'(rg));
            chk(32'(wd), 32'(dv));
            chk(32'(nack_err), 32'h0000_0000);
            chk(32'(reg_addr), (m == 1 && rg != 7'h4f) ? 32'(nx) : 32'(rg));
            model[rg] = int'(dv);
            c0 = rd_cnt;
            do_cmd(1'b0, rg, 8'h00);
            chk(32'(rdata), 32'(model[rg]));
            chk(32'(rd_cnt), 32'(c0 + 1));
            chk(32'(nack_err), 32'h0000_0000);
            chk(32'(reg_addr), (m == 1) ? 32'(nx) : 32'(rg));
            chk(32'({link_inst.scl, link_inst.sda}), 32'h0000_0003);
         end
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire
